// >>> design/pga_pkg.sv
// Constants, field layouts and carrier types of the gain-control and readback block.
// Assumes one 10 MHz clock and a serial frame of 32 bits sent least significant bit first.
package pga_pkg;

  // Serial frame
  localparam int FRAME_BITS = 32;
  localparam logic [4:0] BIT_CNT_LAST = 5'h1F;

  // Address and bank fields of every frame
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 2;
  localparam int BANK_LSB = 3;
  localparam int BANK_MSB = 4;
  localparam logic [2:0] REG_READBACK = 3'h0;
  localparam logic [2:0] REG_SETUP1 = 3'h1;
  localparam logic [1:0] BANK_SETUP = 2'h1;

  // Setup register 1 fields
  localparam int GAIN_LSB = 12;
  localparam int GAIN_MSB = 16;
  localparam int STEP_BIT = 28;
  localparam logic [4:0] GAIN_RESET = 5'h00;
  localparam logic STEP_RESET = 1'b0;
  localparam logic [4:0] GAIN_MAX = 5'h18;

  // Readback word contents
  localparam logic [7:0] OFFSET_MID = 8'h80;
  localparam logic [1:0] VERSION_VALUE = 2'h2;  // Arbitrary value
  localparam logic [8:0] UNUSED_FILL = 9'h000;

  typedef struct packed {
    logic step_2db;
    logic [4:0] gain;
  } setup1_t;

  typedef struct packed {
    logic [7:0] inphase;
    logic [7:0] quad;
  } offsets_t;

  typedef struct packed {
    logic [7:0] inphase_offset_code;
    logic [7:0] quad_offset_code;
    logic [8:0] unused_bits;
    logic [1:0] version_field;
    logic [1:0] bank;
    logic [2:0] addr;
  } readback_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT_OUT = 2'b10
  } rb_state_t;

endpackage : pga_pkg

// >>> design/gain_reduce.sv
// Effective gain computation: programmed gain less the scaled fast-reduction count.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module gain_reduce (
  // Programmed setting
  input wire pga_pkg::setup1_t setup_i,
  // Fast-reduction count, bit 2 most significant
  input wire logic [2:0] fast_reduce_i,
  // Result
  output logic [4:0] gain_o
);

  logic [4:0] clamped;
  logic [4:0] scaled;

  always_comb begin
    clamped = (setup_i.gain > pga_pkg::GAIN_MAX) ? pga_pkg::GAIN_MAX : setup_i.gain;
    scaled = setup_i.step_2db ? {1'b0, fast_reduce_i, 1'b0} : {2'b00, fast_reduce_i};
    if (scaled > clamped) begin
      gain_o = 5'h00;
    end else begin
      gain_o = clamped - scaled;
    end
  end

endmodule : gain_reduce

// >>> design/offset_store.sv
// Holder of the two 8-bit offset correction codes, read data from flip-flops.
// Assumes the calibration logic outside presents new codes with a one-cycle load pulse.
`timescale 1ns/100ps
module offset_store (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Write side
  input wire logic load_i,
  input wire pga_pkg::offsets_t load_data_i,
  // Read side
  output pga_pkg::offsets_t codes_o
);

  pga_pkg::offsets_t next_codes;

  always_comb begin
    next_codes = codes_o;
    if (load_i) begin
      next_codes = load_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      codes_o <= '{inphase: pga_pkg::OFFSET_MID, quad: pga_pkg::OFFSET_MID};
    end else begin
      codes_o <= next_codes;
    end
  end

endmodule : offset_store

// >>> design/pga_gain_and_readback.sv
// Gain-control and readback logic of a receiver front end: serial frame intake,
// setup register 1 fields, effective gain word and the serial readback word.
// Assumes serial data, latch and fast-reduction pins are synchronous to clock_i.
`timescale 1ns/100ps

module pga_gain_and_readback (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Serial interface
  input wire logic ser_shift_i,
  input wire logic ser_data_i,
  input wire logic ser_latch_i,
  output logic readback_o,
  output logic readback_active_o,
  // Fast-reduction pins
  input wire logic fast_reduce_msb_i,
  input wire logic fast_reduce_mid_i,
  input wire logic fast_reduce_lsb_i,
  // Offset codes from the calibration logic
  input wire logic offset_load_i,
  input wire logic [7:0] inphase_offset_in_i,
  input wire logic [7:0] quad_offset_in_i,
  // Gain and offset outputs
  output logic [4:0] effective_gain_word_o,
  output logic [7:0] inphase_offset_code_o,
  output logic [7:0] quad_offset_code_o
);

  // Frame intake
  logic [pga_pkg::FRAME_BITS-1:0] frame;
  logic [pga_pkg::FRAME_BITS-1:0] next_frame;
  logic [2:0] frame_addr;
  logic [1:0] frame_bank;
  logic setup1_write;
  logic readback_cmd;

  // Setup register 1
  pga_pkg::setup1_t setup1;
  pga_pkg::setup1_t next_setup1;

  // Gain path
  logic [2:0] fast_reduce;
  logic [4:0] gain_calc;
  logic [4:0] next_gain;

  // Readback path
  pga_pkg::rb_state_t rb_state;
  pga_pkg::rb_state_t next_rb_state;
  logic [pga_pkg::FRAME_BITS-1:0] rb_shift;
  logic [pga_pkg::FRAME_BITS-1:0] next_rb_shift;
  logic [4:0] rb_cnt;
  logic [4:0] next_rb_cnt;
  logic next_readback;
  pga_pkg::readback_t rb_word;
  pga_pkg::offsets_t codes;

  // Frame intake: least significant bit arrives first and ends in bit 0
  always_comb begin
    next_frame = frame;
    if (ser_shift_i) begin
      next_frame = {ser_data_i, frame[pga_pkg::FRAME_BITS-1:1]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  assign frame_addr = frame[pga_pkg::ADDR_MSB:pga_pkg::ADDR_LSB];
  assign frame_bank = frame[pga_pkg::BANK_MSB:pga_pkg::BANK_LSB];
  assign setup1_write = ser_latch_i && frame_bank == pga_pkg::BANK_SETUP && frame_addr == pga_pkg::REG_SETUP1;
  assign readback_cmd = ser_latch_i && frame_bank == pga_pkg::BANK_SETUP && frame_addr == pga_pkg::REG_READBACK;

  // Setup register 1: gain field and step-size bit
  always_comb begin
    next_setup1 = setup1;
    if (setup1_write) begin
      next_setup1.gain = frame[pga_pkg::GAIN_MSB:pga_pkg::GAIN_LSB];
      next_setup1.step_2db = frame[pga_pkg::STEP_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      setup1 <= '{step_2db: pga_pkg::STEP_RESET, gain: pga_pkg::GAIN_RESET};
    end else begin
      setup1 <= next_setup1;
    end
  end

  // Gain path: pins act every cycle, no register write needed
  assign fast_reduce = {fast_reduce_msb_i, fast_reduce_mid_i, fast_reduce_lsb_i};

  gain_reduce u_gain_reduce (
    .setup_i(setup1),
    .fast_reduce_i(fast_reduce),
    .gain_o(gain_calc)
  );

  always_comb begin
    next_gain = gain_calc;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      effective_gain_word_o <= pga_pkg::GAIN_RESET;
    end else begin
      effective_gain_word_o <= next_gain;
    end
  end

  // Offset codes
  offset_store u_offset_store (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(offset_load_i),
    .load_data_i(pga_pkg::offsets_t'{inphase: inphase_offset_in_i, quad: quad_offset_in_i}),
    .codes_o(codes)
  );

  assign inphase_offset_code_o = codes.inphase;
  assign quad_offset_code_o = codes.quad;

  // Readback word assembly
  always_comb begin
    rb_word.addr = pga_pkg::REG_READBACK;
    rb_word.bank = pga_pkg::BANK_SETUP;
    rb_word.version_field = pga_pkg::VERSION_VALUE;
    rb_word.unused_bits = pga_pkg::UNUSED_FILL;
    rb_word.quad_offset_code = codes.quad;
    rb_word.inphase_offset_code = codes.inphase;
  end

  // Readback shifter: word captured on the command, then one bit per shift pulse
  always_comb begin
    next_rb_state = rb_state;
    next_rb_shift = rb_shift;
    next_rb_cnt = rb_cnt;
    next_readback = readback_o;
    case (rb_state)
      pga_pkg::ST_IDLE: begin
        if (readback_cmd) begin
          next_rb_state = pga_pkg::ST_SHIFT_OUT;
          next_rb_shift = rb_word;
          next_rb_cnt = 5'h00;
          next_readback = rb_word[0];
        end
      end
      pga_pkg::ST_SHIFT_OUT: begin
        if (ser_shift_i) begin
          if (rb_cnt == pga_pkg::BIT_CNT_LAST) begin
            next_rb_state = pga_pkg::ST_IDLE;
            next_readback = 1'b0;
          end else begin
            next_rb_shift = {1'b0, rb_shift[pga_pkg::FRAME_BITS-1:1]};
            next_rb_cnt = rb_cnt + 5'h01;
            next_readback = rb_shift[1];
          end
        end
      end
      default: begin
        next_rb_state = pga_pkg::ST_IDLE;
        next_readback = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rb_state <= pga_pkg::ST_IDLE;
      rb_shift <= '0;
      rb_cnt <= 5'h00;
      readback_o <= 1'b0;
    end else begin
      rb_state <= next_rb_state;
      rb_shift <= next_rb_shift;
      rb_cnt <= next_rb_cnt;
      readback_o <= next_readback;
    end
  end

  assign readback_active_o = (rb_state == pga_pkg::ST_SHIFT_OUT);

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic [4:0] chk_clamped;
  logic [4:0] chk_scaled;
  assign chk_clamped = (setup1.gain > pga_pkg::GAIN_MAX) ? pga_pkg::GAIN_MAX : setup1.gain;
  assign chk_scaled = setup1.step_2db ? {1'b0, fast_reduce, 1'b0} : {2'b00, fast_reduce};

  sequence s_rb_start;
    rb_state == pga_pkg::ST_IDLE && readback_cmd;
  endsequence

  sequence s_rb_loaded;
    rb_state == pga_pkg::ST_SHIFT_OUT && rb_cnt == 5'h00;
  endsequence

  a_rb_version: assert property (s_rb_start |=> s_rb_loaded and (rb_shift[6:5] == pga_pkg::VERSION_VALUE
    && rb_shift[15:7] == pga_pkg::UNUSED_FILL))
    else $error("readback version or unused bits wrong");

  a_rb_addr_field: assert property (s_rb_start |=> rb_shift[2:0] == 3'h0 && readback_o == rb_shift[0])
    else $error("readback register field wrong");

  a_rb_bank_field: assert property (s_rb_start |=> rb_shift[3] && !rb_shift[4])
    else $error("readback bank field wrong");

  a_rb_quad_code: assert property (s_rb_start |=> rb_shift[23:16] == $past(codes.quad))
    else $error("readback quad code wrong");

  a_rb_inph_code: assert property (s_rb_start |=> rb_shift[31:24] == $past(codes.inphase))
    else $error("readback inphase code wrong");

  a_offset_mid_reset: assert property ($fell(rst_i) |-> codes.quad == pga_pkg::OFFSET_MID
    && codes.inphase == pga_pkg::OFFSET_MID)
    else $error("offset codes not mid-scale after reset");

  a_rb_second_bit: assert property ((s_rb_loaded and ser_shift_i) |=> readback_o == $past(rb_shift[1]))
    else $error("readback bit order wrong");

  a_gain_field_load: assert property (setup1_write |=> setup1.gain == $past(frame[16:12])
    && setup1.step_2db == $past(frame[28]))
    else $error("setup register 1 load wrong");

  a_gain_in_range: assert property (effective_gain_word_o <= pga_pkg::GAIN_MAX)
    else $error("effective gain above range");

  a_gain_subtract: assert property (chk_scaled <= chk_clamped
    |=> effective_gain_word_o == $past(chk_clamped) - $past(chk_scaled))
    else $error("effective gain subtraction wrong");

  a_gain_floor_zero: assert property (chk_scaled > chk_clamped |=> effective_gain_word_o == 5'h00)
    else $error("effective gain did not floor at zero");

  a_gain_max_clamp: assert property (setup1.gain > pga_pkg::GAIN_MAX && fast_reduce == 3'h0
    |=> effective_gain_word_o == pga_pkg::GAIN_MAX)
    else $error("programmed gain not clamped");

  a_fast_step_size: assert property (fast_reduce == 3'h7 && setup1.gain == pga_pkg::GAIN_MAX
    |=> effective_gain_word_o == ($past(setup1.step_2db) ? 5'h0A : 5'h11))
    else $error("fast-reduction depth wrong");

  a_fast_pin_order: assert property (fast_reduce_msb_i && !fast_reduce_mid_i && fast_reduce_lsb_i
    && !setup1.step_2db && setup1.gain == pga_pkg::GAIN_MAX |=> effective_gain_word_o == 5'h13)
    else $error("fast-reduction pin weighting wrong");

  sequence s_rb_step;
    readback_active_o && ser_shift_i;
  endsequence

  a_rb_start_bit: assert property (s_rb_start |=> readback_active_o && !readback_o)
    else $error("readback did not start with register field bit 0");

  a_rb_shift_step: assert property ((s_rb_step and rb_cnt != pga_pkg::BIT_CNT_LAST)
    |=> readback_o == $past(rb_shift[1]) && rb_cnt == $past(rb_cnt) + 5'h01)
    else $error("readback shift step wrong");

  a_rb_word_end: assert property ((s_rb_step and rb_cnt == pga_pkg::BIT_CNT_LAST)
    |=> !readback_active_o && !readback_o)
    else $error("readback word length wrong");

  a_rb_idle_low: assert property (!readback_active_o |-> !readback_o)
    else $error("readback line not low while idle");

  a_setup_hold: assert property (!setup1_write |=> $stable(setup1))
    else $error("setup register changed without a write");

  a_offset_load: assert property (offset_load_i |=> codes.inphase == $past(inphase_offset_in_i)
    && codes.quad == $past(quad_offset_in_i))
    else $error("offset codes not loaded");

  a_offset_hold: assert property (!offset_load_i |=> $stable(codes))
    else $error("offset codes changed without a load");

  a_gain_pins_cut: assert property (setup1.gain == pga_pkg::GAIN_MAX && !setup1.step_2db
    |=> effective_gain_word_o == pga_pkg::GAIN_MAX - 5'($past(fast_reduce)))
    else $error("fast-reduction pins did not cut gain");

endmodule : pga_gain_and_readback

// >>> testbench/serial_host.sv
// Serial host model: sends 32-bit frames least significant bit first, reads the readback word.
// Assumes the block samples data at edges where the shift strobe is high.
`timescale 1ns/100ps
module serial_host (
  // Clock
  input wire logic clock_i,
  // Serial pins toward the block
  output logic ser_shift_o,
  output logic ser_data_o,
  output logic ser_latch_o,
  // Readback from the block
  input wire logic readback_i
);
  initial begin
    ser_shift_o = 1'b0;
    ser_data_o = 1'b0;
    ser_latch_o = 1'b0;
  end

  task automatic send_frame(input logic [31:0] word);
    for (int k = 0; k < 32; k++) begin
      @(posedge clock_i);
      ser_shift_o <= 1'b1;
      ser_data_o <= word[k];
    end
    @(posedge clock_i);
    ser_shift_o <= 1'b0;
    // Released data line shows the inverse of its last bit
    ser_data_o <= ~word[31];
    ser_latch_o <= 1'b1;
    @(posedge clock_i);
    ser_latch_o <= 1'b0;
  endtask : send_frame

  task automatic read_word(output logic [31:0] word);
    send_frame(32'h0000_0008);
    for (int k = 0; k < 32; k++) begin
      @(negedge clock_i);
      word[k] = readback_i;
      @(posedge clock_i);
      ser_shift_o <= 1'b1;
      ser_data_o <= ~ser_data_o;
      @(posedge clock_i);
      ser_shift_o <= 1'b0;
    end
  endtask : read_word
endmodule : serial_host

// >>> testbench/test_pga_gain_and_readback.sv
// Self-checking bench of the gain-control and readback block.
// Assumes the serial host model owns the serial pins.
`timescale 1ns/100ps
module test_pga_gain_and_readback;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ser_shift, ser_data, ser_latch, readback, readback_active;
  logic [2:0] fast = 3'h0;
  logic offset_load = 1'b0;
  logic [7:0] inphase_in = 8'h00;
  logic [7:0] quad_in = 8'h00;
  logic [4:0] gain_word;
  logic [7:0] inphase_code, quad_code;
  logic [31:0] word;
  int fail_count = 0;
  int compares = 0;
  logic [4:0] gain_list [5] = '{5'h00, 5'h05, 5'h11, 5'h18, 5'h1F};

  always #50 clock_i = ~clock_i;

  pga_gain_and_readback dut_u (
    .clock_i(clock_i), .rst_i(rst_i),
    .ser_shift_i(ser_shift), .ser_data_i(ser_data), .ser_latch_i(ser_latch),
    .readback_o(readback), .readback_active_o(readback_active),
    .fast_reduce_msb_i(fast[2]), .fast_reduce_mid_i(fast[1]), .fast_reduce_lsb_i(fast[0]),
    .offset_load_i(offset_load), .inphase_offset_in_i(inphase_in), .quad_offset_in_i(quad_in),
    .effective_gain_word_o(gain_word), .inphase_offset_code_o(inphase_code), .quad_offset_code_o(quad_code)
  );

  serial_host host_u (
    .clock_i(clock_i), .ser_shift_o(ser_shift), .ser_data_o(ser_data), .ser_latch_o(ser_latch),
    .readback_i(readback)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    compares++;
    if (seen !== expected) begin
      fail_count++;
      $display("FAIL at %0t: seen %0h expected %0h", $time, seen, expected);
    end
  endtask : check

  function automatic logic [4:0] exp_gain(input logic [4:0] g, input logic step, input logic [2:0] f);
    logic [4:0] capped;
    logic [4:0] cut;
    capped = (g > 5'h18) ? 5'h18 : g;
    cut = step ? {1'b0, f, 1'b0} : {2'h0, f};
    return (capped > cut) ? capped - cut : 5'h00;
  endfunction : exp_gain

  function automatic logic [31:0] rb_word(input logic [7:0] i_code, input logic [7:0] q_code);
    return {i_code, q_code, 9'h000, pga_pkg::VERSION_VALUE, 2'h1, 3'h0};
  endfunction : rb_word

  task automatic read_check(input logic [31:0] expected);
    host_u.read_word(word);
    check(word, expected);
    @(negedge clock_i);
    check(32'({readback_active, readback}), 32'h0);
  endtask : read_check

  task automatic gain_sweep(input logic [4:0] g, input logic step);
    logic [31:0] frame;
    frame = 32'h0000_0009;
    frame[16:12] = g;
    frame[28] = step;
    host_u.send_frame(frame);
    for (int f = 0; f < 8; f++) begin
      @(posedge clock_i);
      fast <= 3'(f);
      @(posedge clock_i);
      @(negedge clock_i);
      check(32'(gain_word), 32'(exp_gain(g, step, 3'(f))));
    end
  endtask : gain_sweep

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    #2000000;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    check(32'({gain_word, inphase_code, quad_code}), 32'h0000_8080);
    read_check(rb_word(8'h80, 8'h80));
    $display("test reset_values done");
    // Gain 17 is the nominal setting of the controller
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 2; s++) begin
        gain_sweep(gain_list[i], 1'(s));
      end
    end
    $display("test gain_sweep done");
    @(posedge clock_i);
    fast <= 3'h0;
    // Wrong bank: the gain field must be ignored
    host_u.send_frame(32'h0000_F011);
    @(posedge clock_i);
    @(posedge clock_i);
    @(negedge clock_i);
    check(32'(gain_word), 32'h18);
    $display("test foreign_frame done");
    @(posedge clock_i);
    offset_load <= 1'b1;
    inphase_in <= 8'h3C;
    quad_in <= 8'hA5;
    @(posedge clock_i);
    offset_load <= 1'b0;
    inphase_in <= 8'h00;
    quad_in <= 8'h00;
    @(negedge clock_i);
    check(32'({inphase_code, quad_code}), 32'h3CA5);
    read_check(rb_word(8'h3C, 8'hA5));
    $display("test offset_codes done");
    @(posedge clock_i);
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    check(32'({gain_word, inphase_code, quad_code}), 32'h0000_8080);
    read_check(rb_word(8'h80, 8'h80));
    $display("test second_reset done");
    final_report();
  end
endmodule : test_pga_gain_and_readback
